// *** pms_program_memory.sv ***
`timescale 1ns/1ps

// Overview of operation
// - user program occupies 0000-1fff; 2000-efff is reserved and faults
// - 4 kB mask rom is fetched at f000 and above
// - on-chip program store is one-time: a programmed byte changes only when reset clears the whole store
// - bytes 0 to 47 hold configuration data, not code
// - at reset three bytes pack per word, 16 words go to ram 48-63
// - commands raise and drop otp_program_enable; host raises it before writes
// - after reset reads are protected; unprogrammed bytes read zero
// - reading fuse address 8143 holding zero lifts read protection
// - nonzero fuse write followed by fuse read completes protection
// - external eeprom up to 8 kB serves fetches like the internal store
// - boot probes external address 0; 00 or ff selects internal store
// - byte 0 supplies bits 23 to 16 of configuration word 0
// - 128-byte user eeprom, byte-wise load and store
// - ram address pointer also selects the user eeprom byte
// - rom code may return to user memory when configuration allows
// - only eeprom load and store reach eeprom; others reach ram word
// - ram bus has 256 addresses of 24-bit words
module pms_program_memory
   import pms_pkg::*;
#(
   parameter int unsigned UEE_BYTES = PMS_UEE_BYTES
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        cmd_valid,
   input  wire pms_cmd_t    cmd,
   output logic             resp_valid,
   output logic [7:0]       resp_data,
   output logic             otp_program_enable,
   output logic             otp_read_protected,
   output logic             ext_req,
   output logic [12:0]      ext_addr,
   input  wire logic        ext_ack,
   input  wire logic [7:0]  ext_data,
   output logic             boot_done,
   output logic             exec_from_ext,
   output pms_cfg_wr_t      cfg_wr,
   input  wire logic        fetch_req,
   input  wire logic [15:0] fetch_addr,
   output logic             fetch_ready,
   output logic             fetch_valid,
   output logic [7:0]       fetch_data,
   output logic             fetch_fault,
   output logic [11:0]      rom_addr,
   input  wire logic [7:0]  rom_data,
   input  wire pms_cpu_t    cpu,
   output logic             uee_rvalid,
   output logic [7:0]       uee_rdata,
   output logic             ram_sel,
   output logic [7:0]       ram_addr,
   input  wire logic        ret_req,
   input  wire logic        ret_cfg_en,
   output logic             ret_grant
);

   localparam int UEE_AW = $clog2(UEE_BYTES);

   if (UEE_BYTES < 2 || UEE_BYTES > PMS_RAM_WORDS || (UEE_BYTES & (UEE_BYTES - 1)) != 0) begin
      $error("UEE_BYTES must be a power of two from 2 to 256");
   end

   // ==========================================================
   // helpers
   function automatic logic is_blank(input logic [7:0] b);
      return (b == PMS_BLANK_LOW) || (b == PMS_BLANK_HIGH);
   endfunction

   function automatic logic in_user(input logic [15:0] a);
      return a <= PMS_USER_LAST;
   endfunction

   // ==========================================================
   // storage
   logic [7:0]        otp_reg [PMS_USER_BYTES];
   logic [7:0]        uee_reg [UEE_BYTES];
   logic              otp_we;
   logic [12:0]       otp_waddr;
   logic [7:0]        otp_wdata;
   logic              uee_we;
   logic [UEE_AW-1:0] uee_idx;

   // ==========================================================
   // one-time memory command path
   logic otp_program_enable_reg, otp_program_enable_next;
   logic prot_reg, prot_next;
   logic rvld_reg, rvld_next;
   logic [7:0] rdat_reg, rdat_next;

   always_comb begin
      otp_program_enable_next = otp_program_enable_reg;
      prot_next = prot_reg;
      rvld_next = 1'b0;
      rdat_next = rdat_reg;
      otp_we    = 1'b0;
      otp_waddr = cmd.addr;
      otp_wdata = cmd.data;
      if (cmd_valid) begin
         case (cmd.op)
            PMS_CMD_OTP_PROGRAM_ENABLE_ON: begin
               otp_program_enable_next = 1'b1;
            end
            PMS_CMD_OTP_PROGRAM_ENABLE_OFF: begin
               otp_program_enable_next = 1'b0;
            end
            PMS_CMD_WRITE: begin
               otp_we = otp_program_enable_reg && (otp_reg[cmd.addr] == PMS_OTP_ERASED);
            end
            PMS_CMD_READ: begin
               rvld_next = 1'b1;
               if (cmd.addr == PMS_FUSE_ADDR) begin
                  rdat_next = otp_reg[PMS_FUSE_ADDR];
                  prot_next = (otp_reg[PMS_FUSE_ADDR] != PMS_OTP_ERASED);
               end else if (prot_reg) begin
                  rdat_next = PMS_OTP_ERASED;
               end else begin
                  rdat_next = otp_reg[cmd.addr];
               end
            end
            default: begin
               rvld_next = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         otp_program_enable_reg <= 1'b0;
         prot_reg <= 1'b1;
         rvld_reg <= 1'b0;
         rdat_reg <= 8'h00;
      end else begin
         otp_program_enable_reg <= otp_program_enable_next;
         prot_reg <= prot_next;
         rvld_reg <= rvld_next;
         rdat_reg <= rdat_next;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < PMS_USER_BYTES; i++) begin
            otp_reg[i] <= PMS_OTP_ERASED;
         end
      end else if (otp_we) begin
         otp_reg[otp_waddr] <= otp_wdata;
      end
   end

   assign resp_valid         = rvld_reg;
   assign resp_data          = rdat_reg;
   assign otp_program_enable = otp_program_enable_reg;
   assign otp_read_protected = prot_reg;

   // ==========================================================
   // boot copy and instruction fetch
   pms_state_t  st_reg, st_next;
   logic        src_reg, src_next;
   logic        done_reg, done_next;
   logic [12:0] idx_reg, idx_next;
   logic [1:0]  bcnt_reg, bcnt_next;
   logic [15:0] acc_reg, acc_next;
   logic        ereq_reg, ereq_next;
   logic [12:0] eadr_reg, eadr_next;
   pms_cfg_wr_t cfg_reg, cfg_next;
   logic        fvld_reg, fvld_next;
   logic [7:0]  fdat_reg, fdat_next;
   logic        fflt_reg, fflt_next;
   logic        frdy_reg, frdy_next;
   logic [11:0] radr_reg, radr_next;
   logic        take;
   logic [7:0]  byte_in;

   always_comb begin
      st_next   = st_reg;
      src_next  = src_reg;
      done_next = done_reg;
      idx_next  = idx_reg;
      bcnt_next = bcnt_reg;
      acc_next  = acc_reg;
      ereq_next = ereq_reg;
      eadr_next = eadr_reg;
      cfg_next  = '0;
      fvld_next = 1'b0;
      fdat_next = fdat_reg;
      fflt_next = 1'b0;
      radr_next = radr_reg;
      take      = 1'b0;
      byte_in   = otp_reg[idx_reg];
      case (st_reg)
         PMS_ST_PROBE: begin
            ereq_next = 1'b1;
            eadr_next = PMS_PROBE_ADDR;
            st_next   = PMS_ST_PWAIT;
         end
         PMS_ST_PWAIT: begin
            if (ext_ack) begin
               ereq_next = 1'b0;
               src_next  = !is_blank(ext_data);
               st_next   = PMS_ST_COPY;
            end
         end
         PMS_ST_COPY: begin
            if (src_reg) begin
               ereq_next = 1'b1;
               eadr_next = idx_reg;
               st_next   = PMS_ST_CWAIT;
            end else begin
               take = 1'b1;
            end
         end
         PMS_ST_CWAIT: begin
            byte_in = ext_data;
            if (ext_ack) begin
               ereq_next = 1'b0;
               take      = 1'b1;
               st_next   = PMS_ST_COPY;
            end
         end
         PMS_ST_IDLE: begin
            if (fetch_req) begin
               if (in_user(fetch_addr)) begin
                  if (src_reg) begin
                     ereq_next = 1'b1;
                     eadr_next = fetch_addr[12:0];
                     st_next   = PMS_ST_FEXT;
                  end else begin
                     fvld_next = 1'b1;
                     fdat_next = otp_reg[fetch_addr[12:0]];
                  end
               end else if (fetch_addr >= PMS_ROM_BASE) begin
                  radr_next = fetch_addr[11:0];
                  st_next   = PMS_ST_FROM;
               end else begin
                  fvld_next = 1'b1;
                  fflt_next = 1'b1;
                  fdat_next = 8'h00;
               end
            end
         end
         PMS_ST_FEXT: begin
            if (ext_ack) begin
               ereq_next = 1'b0;
               fvld_next = 1'b1;
               fdat_next = ext_data;
               st_next   = PMS_ST_IDLE;
            end
         end
         PMS_ST_FROM: begin
            fvld_next = 1'b1;
            fdat_next = rom_data;
            st_next   = PMS_ST_IDLE;
         end
         default: begin
            st_next = PMS_ST_PROBE;
         end
      endcase
      if (take) begin
         acc_next  = {acc_reg[7:0], byte_in};
         bcnt_next = (bcnt_reg == PMS_BYTE_LAST) ? 2'h0 : bcnt_reg + 2'h1;
         idx_next  = idx_reg + 13'h0001;
         if (bcnt_reg == PMS_BYTE_LAST) begin
            cfg_next.valid = 1'b1;
            cfg_next.addr  = PMS_CFG_RAM_BASE + 8'(idx_reg / 13'd3);
            cfg_next.data  = {acc_reg, byte_in};
         end
         if (idx_reg == PMS_CFG_LAST) begin
            done_next = 1'b1;
            st_next   = PMS_ST_IDLE;
         end
      end
      frdy_next = (st_next == PMS_ST_IDLE);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg   <= PMS_ST_PROBE;
         src_reg  <= 1'b0;
         done_reg <= 1'b0;
         idx_reg  <= 13'h0000;
         bcnt_reg <= 2'h0;
         acc_reg  <= 16'h0000;
         ereq_reg <= 1'b0;
         eadr_reg <= 13'h0000;
         cfg_reg  <= '0;
         fvld_reg <= 1'b0;
         fdat_reg <= 8'h00;
         fflt_reg <= 1'b0;
         frdy_reg <= 1'b0;
         radr_reg <= 12'h000;
      end else begin
         st_reg   <= st_next;
         src_reg  <= src_next;
         done_reg <= done_next;
         idx_reg  <= idx_next;
         bcnt_reg <= bcnt_next;
         acc_reg  <= acc_next;
         ereq_reg <= ereq_next;
         eadr_reg <= eadr_next;
         cfg_reg  <= cfg_next;
         fvld_reg <= fvld_next;
         fdat_reg <= fdat_next;
         fflt_reg <= fflt_next;
         frdy_reg <= frdy_next;
         radr_reg <= radr_next;
      end
   end

   assign ext_req       = ereq_reg;
   assign ext_addr      = eadr_reg;
   assign boot_done     = done_reg;
   assign exec_from_ext = src_reg;
   assign cfg_wr        = cfg_reg;
   assign fetch_ready   = frdy_reg;
   assign fetch_valid   = fvld_reg;
   assign fetch_data    = fdat_reg;
   assign fetch_fault   = fflt_reg;
   assign rom_addr      = radr_reg;

   // ==========================================================
   // ram pointer, user eeprom and rom return
   logic       urv_reg, urv_next;
   logic [7:0] urd_reg, urd_next;
   logic       rs_reg, rs_next;
   logic [7:0] ra_reg, ra_next;
   logic       rg_reg, rg_next;

   always_comb begin
      uee_idx  = cpu.ptr[UEE_AW-1:0];
      uee_we   = 1'b0;
      urv_next = 1'b0;
      urd_next = urd_reg;
      rs_next  = 1'b0;
      ra_next  = ra_reg;
      if (cpu.valid) begin
         case (cpu.op)
            PMS_CPU_GETEPR: begin
               urv_next = 1'b1;
               urd_next = uee_reg[uee_idx];
            end
            PMS_CPU_PUTEPR: begin
               uee_we = 1'b1;
            end
            default: begin
               rs_next = 1'b1;
               ra_next = cpu.ptr;
            end
         endcase
      end
      rg_next = ret_req && ret_cfg_en && done_reg;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         urv_reg <= 1'b0;
         urd_reg <= 8'h00;
         rs_reg  <= 1'b0;
         ra_reg  <= 8'h00;
         rg_reg  <= 1'b0;
      end else begin
         urv_reg <= urv_next;
         urd_reg <= urd_next;
         rs_reg  <= rs_next;
         ra_reg  <= ra_next;
         rg_reg  <= rg_next;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < UEE_BYTES; i++) begin
            uee_reg[i] <= 8'h00;
         end
      end else if (uee_we) begin
         uee_reg[uee_idx] <= cpu.wdata;
      end
   end

   assign uee_rvalid = urv_reg;
   assign uee_rdata  = urd_reg;
   assign ram_sel    = rs_reg;
   assign ram_addr   = ra_reg;
   assign ret_grant  = rg_reg;

endmodule

// *** pms_pkg.sv ***
package pms_pkg;

   // ==========================================================
   // program address map
   localparam logic [15:0] PMS_USER_LAST  = 16'h1fff;
   localparam logic [15:0] PMS_RSV_LAST   = 16'hefff;
   localparam logic [15:0] PMS_ROM_BASE   = 16'hf000;
   localparam int unsigned PMS_USER_BYTES = 8192;
   localparam int unsigned PMS_ROM_BYTES  = 4096;

   // ==========================================================
   // boot configuration copy
   localparam int unsigned PMS_CFG_BYTES    = 48;
   localparam int unsigned PMS_CFG_WORDS    = 16;
   localparam logic [7:0]  PMS_CFG_RAM_BASE = 8'h30;
   localparam logic [12:0] PMS_CFG_LAST     = 13'h002f;
   localparam logic [1:0]  PMS_BYTE_LAST    = 2'h2;
   localparam logic [12:0] PMS_PROBE_ADDR   = 13'h0000;
   localparam logic [7:0]  PMS_BLANK_LOW    = 8'h00;
   localparam logic [7:0]  PMS_BLANK_HIGH   = 8'hff;

   // ==========================================================
   // one-time memory protection
   localparam logic [12:0] PMS_FUSE_ADDR  = 13'h1fcf;
   localparam logic [7:0]  PMS_OTP_ERASED = 8'h00;

   // ==========================================================
   // ram bus and user eeprom
   localparam int unsigned PMS_RAM_WORDS  = 256;
   localparam int unsigned PMS_UEE_BYTES  = 128;

   typedef enum logic [1:0] {
      PMS_CMD_OTP_PROGRAM_ENABLE_ON  = 2'h0,
      PMS_CMD_OTP_PROGRAM_ENABLE_OFF = 2'h1,
      PMS_CMD_WRITE    = 2'h2,
      PMS_CMD_READ     = 2'h3
   } pms_cmd_op_t;

   typedef struct packed {
      pms_cmd_op_t op;
      logic [12:0] addr;
      logic [7:0]  data;
   } pms_cmd_t;

   typedef enum logic [1:0] {
      PMS_CPU_RAM    = 2'h0,
      PMS_CPU_GETEPR = 2'h1,
      PMS_CPU_PUTEPR = 2'h2
   } pms_cpu_op_t;

   typedef struct packed {
      logic        valid;
      pms_cpu_op_t op;
      logic [7:0]  ptr;
      logic [7:0]  wdata;
   } pms_cpu_t;

   typedef struct packed {
      logic        valid;
      logic [7:0]  addr;
      logic [23:0] data;
   } pms_cfg_wr_t;

   typedef enum logic [6:0] {
      PMS_ST_PROBE = 7'h01,
      PMS_ST_PWAIT = 7'h02,
      PMS_ST_COPY  = 7'h04,
      PMS_ST_CWAIT = 7'h08,
      PMS_ST_IDLE  = 7'h10,
      PMS_ST_FEXT  = 7'h20,
      PMS_ST_FROM  = 7'h40
   } pms_state_t;

endpackage

// *** pms_eeprom_model.sv ***
`timescale 1ns/1ps
module pms_eeprom_model (
   input  logic        clk,
   input  logic        rst_n,
   input  logic        slow,
   input  logic        ext_req,
   input  logic [12:0] ext_addr,
   output logic        ext_ack,
   output logic [7:0]  ext_data
);
   logic [7:0] mem [8192];
   logic [1:0] wait_reg;
   // ==========================================================
   // one read at a time, answered after one or three cycles
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ext_ack  <= 1'b0;
         ext_data <= 8'h0f;
         wait_reg <= 2'h0;
      end else if (ext_req && !ext_ack && wait_reg >= (slow ? 2'h2 : 2'h0)) begin
         ext_ack  <= 1'b1;
         ext_data <= mem[ext_addr];
         wait_reg <= 2'h0;
      end else begin
         ext_ack  <= 1'b0;
         ext_data <= ~ext_data;
         wait_reg <= (ext_req && !ext_ack) ? wait_reg + 2'h1 : 2'h0;
      end
   end
endmodule

// *** pms_checker.sv ***
`timescale 1ns/1ps
module pms_checker
   import pms_pkg::*;
(
   input logic        clk,
   input logic        rst_n,
   input logic        cmd_valid,
   input pms_cmd_t    cmd,
   input logic        resp_valid,
   input logic [7:0]  resp_data,
   input logic        otp_program_enable,
   input logic        otp_read_protected,
   input pms_cfg_wr_t cfg_wr,
   input logic        fetch_req,
   input logic [15:0] fetch_addr,
   input logic        fetch_ready,
   input logic        fetch_valid,
   input logic [7:0]  fetch_data,
   input logic        fetch_fault,
   input logic [11:0] rom_addr,
   input logic [7:0]  rom_data,
   input pms_cpu_t    cpu,
   input logic        uee_rvalid,
   input logic        ram_sel,
   input logic [7:0]  ram_addr,
   input logic        ret_req,
   input logic        ret_cfg_en,
   input logic        boot_done,
   input logic        ret_grant
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire        rd      = cmd_valid && cmd.op == PMS_CMD_READ;
   wire        go      = fetch_req && fetch_ready;
   wire [11:0] rom_off = fetch_addr[11:0];
   wire [7:0]  cpu_ptr = cpu.ptr;
   // ==========================================================
   // assertions
   a_read_answer: assert property (rd |=> resp_valid)
      else $error("read got no answer");
   a_otp_program_enable_on: assert property (cmd_valid && cmd.op == PMS_CMD_OTP_PROGRAM_ENABLE_ON |=> otp_program_enable)
      else $error("enable did not rise");
   a_otp_program_enable_off: assert property (cmd_valid && cmd.op == PMS_CMD_OTP_PROGRAM_ENABLE_OFF |=> !otp_program_enable)
      else $error("enable did not fall");
   a_fuse_state: assert property (rd && cmd.addr == PMS_FUSE_ADDR |=> otp_read_protected == (resp_data != 8'h00))
      else $error("protection not set from fuse");
   a_locked_zero: assert property (rd && cmd.addr != PMS_FUSE_ADDR && otp_read_protected |=> resp_data == 8'h00)
      else $error("protected read leaked data");
   a_cfg_range: assert property (cfg_wr.valid |-> cfg_wr.addr >= PMS_CFG_RAM_BASE && cfg_wr.addr < 8'h40)
      else $error("config word outside 48 to 63");
   a_rsv_fault: assert property (go && fetch_addr > PMS_USER_LAST && fetch_addr <= PMS_RSV_LAST |=> fetch_valid && fetch_fault && fetch_data == 8'h00)
      else $error("reserved fetch not faulted");
   a_rom_path: assert property (go && fetch_addr >= PMS_ROM_BASE |=> rom_addr == $past(rom_off) ##1 fetch_valid && fetch_data == rom_data)
      else $error("rom fetch wrong");
   a_ram_route: assert property (cpu.valid && cpu.op != PMS_CPU_GETEPR && cpu.op != PMS_CPU_PUTEPR |=> ram_sel && ram_addr == $past(cpu_ptr))
      else $error("ram access misrouted");
   a_eep_route: assert property (cpu.valid && cpu.op == PMS_CPU_GETEPR |=> uee_rvalid && !ram_sel)
      else $error("eeprom load misrouted");
   a_ret_grant: assert property (ret_req && ret_cfg_en && boot_done |=> ret_grant)
      else $error("return not granted");
endmodule
bind pms_program_memory pms_checker pms_checker_inst (.clk, .rst_n, .cmd_valid, .cmd,
   .resp_valid, .resp_data, .otp_program_enable, .otp_read_protected, .cfg_wr, .fetch_req,
   .fetch_addr, .fetch_ready, .fetch_valid, .fetch_data, .fetch_fault, .rom_addr, .rom_data,
   .cpu, .uee_rvalid, .ram_sel, .ram_addr, .ret_req, .ret_cfg_en, .boot_done, .ret_grant);

// *** pms_program_memory_tb.sv ***
`timescale 1ns/1ps
module pms_program_memory_tb
   import pms_pkg::*;
   ;
   logic        clk = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0, fetch_req = 1'b0, slow;
   logic        ret_req = 1'b0, ret_cfg_en = 1'b0, ext_ack, resp_valid, ext_req;
   logic        otp_program_enable, otp_read_protected, boot_done, exec_from_ext;
   logic        fetch_ready, fetch_valid, fetch_fault, uee_rvalid, ram_sel, ret_grant;
   pms_cmd_t    cmd = '0;
   pms_cpu_t    cpu = '0;
   pms_cfg_wr_t cfg_wr;
   logic [15:0] fetch_addr = '0;
   logic [12:0] ext_addr, ad;
   logic [11:0] rom_addr;
   logic [7:0]  ext_data, rom_data, resp_data, fetch_data, uee_rdata, ram_addr, d;
   logic [7:0]  otp_m [8192];
   logic [7:0]  uee_m [128];
   logic        prot_m, en_m, ext_m;
   int          fails = 0, num_checks = 0, cyc = 0, cfg_n = 0, a;

   pms_program_memory pms_program_memory_inst (.clk, .rst_n, .cmd_valid, .cmd, .resp_valid,
      .resp_data, .otp_program_enable, .otp_read_protected, .ext_req, .ext_addr, .ext_ack,
      .ext_data, .boot_done, .exec_from_ext, .cfg_wr, .fetch_req, .fetch_addr, .fetch_ready,
      .fetch_valid, .fetch_data, .fetch_fault, .rom_addr, .rom_data, .cpu, .uee_rvalid,
      .uee_rdata, .ram_sel, .ram_addr, .ret_req, .ret_cfg_en, .ret_grant);
   pms_eeprom_model pms_eeprom_model_inst (.clk, .rst_n, .slow, .ext_req, .ext_addr,
      .ext_ack, .ext_data);

   assign rom_data = rom_addr[7:0] ^ rom_addr[11:4];
   always #2 clk = ~clk;
   // ==========================================================
   // checking and closing
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task final_report;
      $display("checks=%0d fails=%0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         final_report();
      end
   end
   always @(negedge clk) if (rst_n && cfg_wr.valid) begin
      check(cfg_wr.addr, 48 + cfg_n);
      check(cfg_wr.data, ext_m ? {pms_eeprom_model_inst.mem[3*cfg_n],
         pms_eeprom_model_inst.mem[3*cfg_n+1], pms_eeprom_model_inst.mem[3*cfg_n+2]} : 0);
      cfg_n++;
   end
   // ==========================================================
   // bus tasks
   task automatic boot(input logic [7:0] v);
      int n;
      pms_eeprom_model_inst.mem[0] = v;
      ext_m = v != 8'h00 && v != 8'hff;
      cfg_n = 0;
      prot_m = 1'b1;
      en_m = 1'b0;
      foreach (otp_m[k]) otp_m[k] = 8'h00;
      foreach (uee_m[k]) uee_m[k] = 8'h00;
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      check(otp_read_protected, 1);
      for (n = 0; n < 2000 && boot_done !== 1'b1; n++) @(negedge clk);
      // let the word monitor count the last pulse first
      @(posedge clk);
      check(exec_from_ext, ext_m);
      check(cfg_n, 16);
   endtask
   task automatic op(input pms_cmd_op_t o, input logic [12:0] ar, input logic [7:0] dt);
      logic [7:0] e;
      e = (prot_m && ar != PMS_FUSE_ADDR) ? 8'h00 : otp_m[ar];
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd <= pms_cmd_t'{o, ar, dt};
      @(posedge clk);
      cmd_valid <= 1'b0;
      @(negedge clk);
      if (o == PMS_CMD_WRITE && en_m && otp_m[ar] == 8'h00) otp_m[ar] = dt;
      if (o == PMS_CMD_OTP_PROGRAM_ENABLE_ON || o == PMS_CMD_OTP_PROGRAM_ENABLE_OFF) en_m = o == PMS_CMD_OTP_PROGRAM_ENABLE_ON;
      check(otp_program_enable, en_m);
      check(resp_valid, o == PMS_CMD_READ);
      if (o == PMS_CMD_READ) begin
         check(resp_data, e);
         if (ar == PMS_FUSE_ADDR) prot_m = otp_m[ar] != 8'h00;
         check(otp_read_protected, prot_m);
      end
   endtask
   task automatic fetch(input logic [15:0] fa, input logic [7:0] e, input logic f);
      int n;
      for (n = 0; n < 100 && fetch_ready !== 1'b1; n++) @(negedge clk);
      @(posedge clk);
      fetch_req <= 1'b1;
      fetch_addr <= fa;
      @(posedge clk);
      fetch_req <= 1'b0;
      @(negedge clk);
      for (n = 0; n < 100 && fetch_valid !== 1'b1; n++) @(negedge clk);
      check(fetch_data, e);
      check(fetch_fault, f);
   endtask
   task automatic cpu_op(input pms_cpu_op_t o, input logic [7:0] p, input logic [7:0] w);
      @(posedge clk);
      cpu <= pms_cpu_t'{1'b1, o, p, w};
      @(posedge clk);
      cpu.valid <= 1'b0;
      @(negedge clk);
      check(ram_sel, o != PMS_CPU_GETEPR && o != PMS_CPU_PUTEPR);
      check(uee_rvalid, o == PMS_CPU_GETEPR);
      if (o == PMS_CPU_PUTEPR) uee_m[p[6:0]] = w;
      if (o == PMS_CPU_GETEPR) check(uee_rdata, uee_m[p[6:0]]);
      if (o != PMS_CPU_GETEPR && o != PMS_CPU_PUTEPR) check(ram_addr, p);
   endtask
   // ==========================================================
   // main sequence
   initial begin
      d = 8'($urandom(29756));
      for (a = 0; a < 8192; a++) pms_eeprom_model_inst.mem[a] = 8'($urandom);
      slow = 1'b1;
      boot(8'h5a);
      fetch(16'h0005, pms_eeprom_model_inst.mem[5], 1'b0);
      fetch(16'h1fff, pms_eeprom_model_inst.mem[8191], 1'b0);
      slow = 1'b0;
      boot(8'hff);
      boot(8'h00);
      op(PMS_CMD_WRITE, 13'h0040, 8'h3c);
      op(PMS_CMD_OTP_PROGRAM_ENABLE_ON, 13'h0000, 8'h00);
      op(PMS_CMD_WRITE, 13'h0040, 8'h3c);
      op(PMS_CMD_WRITE, 13'h0040, 8'hc3);
      op(PMS_CMD_READ, 13'h0040, 8'h00);
      op(PMS_CMD_READ, PMS_FUSE_ADDR, 8'h00);
      op(PMS_CMD_READ, 13'h0040, 8'h00);
      op(PMS_CMD_WRITE, 13'h1fff, d);
      for (a = 0; a < 10; a++) begin
         ad = 13'($urandom_range(48, 8000));
         op(PMS_CMD_WRITE, ad, 8'($urandom));
         op(PMS_CMD_READ, ad, 8'h00);
      end
      fetch(16'h0040, otp_m[64], 1'b0);
      fetch(16'h1fff, otp_m[8191], 1'b0);
      fetch(16'h2000, 8'h00, 1'b1);
      fetch(16'hefff, 8'h00, 1'b1);
      fetch(16'hf000, 8'h00, 1'b0);
      fetch(16'hfabc, 8'hbc ^ 8'hab, 1'b0);
      op(PMS_CMD_WRITE, PMS_FUSE_ADDR, 8'h01);
      op(PMS_CMD_READ, PMS_FUSE_ADDR, 8'h00);
      op(PMS_CMD_READ, 13'h0040, 8'h00);
      op(PMS_CMD_OTP_PROGRAM_ENABLE_OFF, 13'h0000, 8'h00);
      for (a = 0; a < 6; a++) begin
         d = 8'($urandom);
         cpu_op(PMS_CPU_PUTEPR, d, 8'($urandom));
         cpu_op(PMS_CPU_GETEPR, d ^ 8'h80, 8'h00);
         cpu_op(PMS_CPU_RAM, d, 8'h00);
         cpu_op(pms_cpu_op_t'(2'h3), ~d, 8'h00);
      end
      for (a = 0; a < 2; a++) begin
         @(posedge clk);
         ret_req <= 1'b1;
         ret_cfg_en <= a[0];
         @(posedge clk);
         ret_req <= 1'b0;
         @(negedge clk);
         check(ret_grant, a[0]);
      end
      final_report();
   end
endmodule
